// ---- dv/wdc_top_sva.sv ----
// Assertions on the watchdog control ports.
`timescale 1ns/1ns
module wdc_top_sva (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ctrl_wr_in,
    input wire logic [7:0] ctrl_wdata_in,
    input wire logic supply_monitor_irq_in,
    input wire logic [7:0] ctrl_rdata_out,
    input wire logic wdt_reset_req_out,
    input wire logic wdt_irq_out,
    input wire logic wdt_irq_high_prio_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // Cycles since a write, reset or supply event; it saturates so it never wraps.
    logic [2:0] quiet;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || ctrl_wr_in || supply_monitor_irq_in) begin
            quiet <= 3'h0;
        end else if (quiet != 3'h7) begin
            quiet <= quiet + 3'h1;
        end
    end
    sequence s_calm;
        (!wdt_reset_req_out && !$rose(wdt_irq_out)) [*8];
    endsequence
    ////////////////////////////////////////////////////////////
    chk_prio_fixed: assert property (!$past(sys_rst_in, 2) |-> wdt_irq_high_prio_out)
        else $error("priority marker low");
    chk_code8_reset: assert property ($rose(ctrl_rdata_out[1]) && ctrl_rdata_out[7:4] == 4'h8
        |-> ##[0:4] wdt_reset_req_out) else $error("no immediate reset");
    chk_irq_sel: assert property (wdt_irq_out |-> ctrl_rdata_out[3])
        else $error("interrupt without select");
    chk_reset_sel: assert property (wdt_reset_req_out |-> !ctrl_rdata_out[3] || ctrl_rdata_out[7])
        else $error("reset while interrupt chosen");
    chk_status_set: assert property ($rose(wdt_irq_out) || wdt_reset_req_out
        |-> ##[0:3] ctrl_rdata_out[2]) else $error("status not set");
    chk_status_hold: assert property ($fell(ctrl_rdata_out[2]) |-> quiet < 3'h7)
        else $error("status cleared alone");
    chk_enable_hold: assert property ($fell(ctrl_rdata_out[1])
        |-> quiet < 3'h7 || $past(wdt_reset_req_out)) else $error("enable cleared alone");
    chk_cfg_locked: assert property ($changed(ctrl_rdata_out[7:3]) |-> quiet < 3'h5)
        else $error("config changed unasked");
    chk_refresh_calm: assert property (ctrl_wr_in && !ctrl_wdata_in[7] |=> s_calm)
        else $error("timeout after refresh");
endmodule // wdc_top_sva
bind wdc_top wdc_top_sva u_sva (.*);

// ---- dv/wdc_top_tb.sv ----
// Directed bench for the watchdog control logic.
`timescale 1ns/1ns
module wdc_top_tb import wdc_pkg::*;;
    logic clk_in = 0, sys_rst_in = 1, xtal_clk_in = 0, insn_done_in = 0, ctrl_wr_in = 0;
    logic unlock_set_in = 0, supply_monitor_irq_in = 0, wdt_reset_seen_in = 0;
    logic [7:0] ctrl_wdata_in = 0, ctrl_rdata_out;
    logic wdt_reset_req_out, wdt_irq_out, wdt_irq_high_prio_out;
    int error_cnt = 0, check_count = 0, cyc = 0, n;
    wdc_top DUT (.*);
    always #25 clk_in = ~clk_in;
    // Crystal is sped up to 7 clocks a tick so a whole timeout fits the run.
    // The crystal is offset so that its edges never meet a clock edge.
    initial begin
        #12;
        forever #175 xtal_clk_in = ~xtal_clk_in;
    end
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic step(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    // nothing in between
    // The write is itself an instruction, so it also ends the unlock.
    task automatic wr(input logic [7:0] d);
        unlock_set_in = 1;
        step(1);
        unlock_set_in = 0;
        step(1);
        ctrl_wr_in = 1;
        insn_done_in = 1;
        ctrl_wdata_in = d;
        step(1);
        ctrl_wr_in = 0;
        insn_done_in = 0;
        step(2);
    endtask
    task automatic rst(input logic s);
        sys_rst_in = 1;
        wdt_reset_seen_in = s;
        step(2);
        sys_rst_in = 0;
        wdt_reset_seen_in = 0;
        step(3);
    endtask
    task automatic wt(output int c);
        c = 0;
        while (wdt_irq_out !== 1'b1 && wdt_reset_req_out !== 1'b1 && c < 8000) begin
            step(1);
            c++;
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        step(5);
        sys_rst_in = 0;
        step(2);
        chk(ctrl_rdata_out, WDC_CTRL_RESET);
        chk({7'h0, wdt_irq_high_prio_out}, 8'h01);
        ctrl_wr_in = 1;
        ctrl_wdata_in = 8'h0a;
        step(1);
        ctrl_wr_in = 0;
        step(3);
        chk(ctrl_rdata_out, 8'h10);
        unlock_set_in = 1;
        step(1);
        unlock_set_in = 0;
        insn_done_in = 1;
        step(2);
        insn_done_in = 0;
        ctrl_wr_in = 1;
        step(1);
        ctrl_wr_in = 0;
        step(3);
        chk(ctrl_rdata_out, 8'h10);
        wr(8'h0a);
        step(2000);
        wr(8'h0a);
        wt(n);
        chk({6'h0, wdt_irq_out, wdt_reset_req_out}, 8'h02);
        chk(8'(n > 3560 && n < 3620), 8'h01);
        step(3);
        chk(ctrl_rdata_out, 8'h0e);
        wr(8'h00);
        chk({6'h0, wdt_irq_out, wdt_reset_req_out}, 8'h00);
        chk(ctrl_rdata_out, 8'h00);
        wr(8'h02);
        wt(n);
        chk({6'h0, wdt_irq_out, wdt_reset_req_out}, 8'h01);
        step(4);
        chk(ctrl_rdata_out & 8'h04, 8'h04);
        rst(1);
        chk(ctrl_rdata_out, 8'h14);
        rst(0);
        chk(ctrl_rdata_out, 8'h10);
        wr(8'h8a);
        step(3);
        chk({wdt_irq_out, ctrl_rdata_out[2]}, 2'h1);
        rst(0);
        wr(8'h12);
        supply_monitor_irq_in = 1;
        step(6);
        supply_monitor_irq_in = 0;
        chk(ctrl_rdata_out, 8'h10);
        results();
    end
endmodule // wdc_top_tb

// ---- inc/wdc_pkg.sv ----
// Constants and types shared by the watchdog control logic.
// What this block does
// R1 - The control bits 7 to 4 hold the prescale, and codes 0 to 7 time out after 2^code x 512 crystal periods.
// R2 - Prescale code 1000 forces a system reset at once, whatever response is chosen.
// R3 - Software must not program prescale codes above 1000, which are reserved.
// R4 - With bit 3 set, expiry raises a watchdog interrupt; with it clear, expiry resets the system.
// R5 - The watchdog interrupt ignores the global interrupt enable and has a fixed high priority.
// R6 - Bit 2, the timeout status flag, sets on every timeout, whether it causes a reset or an interrupt.
// R7 - The status flag clears only on a software write of 0 or an external hardware reset.
// R8 - Writing 1 to the enable bit 1 enables the watchdog and clears its counters.
// R9 - Software must rewrite the enable bit within each period, or the selected action is taken.
// R10 - The enable bit clears on a write of 0, a watchdog reset, a hardware reset or a supply-monitor interrupt.
// R11 - Software sets the unlock bit 0 and writes the control register as the very next instruction.
// R12 - Control register writes are accepted only as the second step of the unlock sequence; here a write after one other instruction is accepted too.
// R13 - Software should disable global interrupts around the unlock sequence.
// R14 - The unlock drops by itself after the instruction that follows it; here it outlives one non-write instruction and drops after the next.
package wdc_pkg;
    localparam int WDC_PRE_MSB = 7;
    localparam int WDC_PRE_LSB = 4;
    localparam int WDC_IRQ_SEL_BIT = 3;
    localparam int WDC_STATUS_BIT = 2;
    localparam int WDC_ENABLE_BIT = 1;
    localparam int WDC_UNLOCK_BIT = 0;
    localparam logic [7:0] WDC_CTRL_RESET = 8'h10;
    localparam logic [3:0] WDC_PRE_IMMEDIATE = 4'h8;
    localparam int WDC_BASE_TICKS = 512;
    localparam int WDC_COUNT_W = 16;
    localparam int WDC_SYNC_STAGES = 2;
    typedef enum logic [2:0] {
        WDC_IDLE = 3'b001,
        WDC_RUN = 3'b010,
        WDC_FIRE = 3'b100
    } wdc_state_t;
endpackage

// ---- rtl/wdc_sync.sv ----
// Two-flop synchroniser for a level that arrives from outside the clock domain.
`timescale 1ns/1ns
module wdc_sync import wdc_pkg::*; (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            meta <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule // wdc_sync

// ---- rtl/wdc_top.sv ----
// Watchdog control register, unlock sequence, prescaled timeout and response logic.
`timescale 1ns/1ns
module wdc_top import wdc_pkg::*; (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic xtal_clk_in,
    input wire logic insn_done_in,
    input wire logic ctrl_wr_in,
    input wire logic [7:0] ctrl_wdata_in,
    input wire logic unlock_set_in,
    input wire logic supply_monitor_irq_in,
    input wire logic wdt_reset_seen_in,
    output logic [7:0] ctrl_rdata_out,
    output logic wdt_reset_req_out,
    output logic wdt_irq_out,
    output logic wdt_irq_high_prio_out
);
    ////////////////////////////////////////////////////////////////////////////////
    logic xtal_sync;
    logic xtal_prev;
    logic xtal_tick;
    logic smi_sync;
    logic [3:0] prescale;
    logic irq_sel;
    logic status_flag;
    logic enable;
    logic unlock;
    logic unlock_armed;
    logic [WDC_COUNT_W-1:0] count;
    logic [WDC_COUNT_W-1:0] limit;
    logic expire;
    logic immediate;
    logic wr_ok;
    wdc_state_t state;

    wdc_sync u_xtal_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .d_in(xtal_clk_in),
        .q_out(xtal_sync)
    );
    wdc_sync u_smi_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .d_in(supply_monitor_irq_in),
        .q_out(smi_sync)
    );

    // The crystal is slow against clk_in, so a rising edge becomes one tick.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            xtal_prev <= 1'b0;
        end else begin
            xtal_prev <= xtal_sync;
        end
    end
    assign xtal_tick = xtal_sync & ~xtal_prev;

    ////////////////////////////////////////////////////////////////////////////////
    // R14 unlock auto drop
    // The unlock falls after a following write instruction, or else after the second following instruction.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            unlock <= 1'b0;
            unlock_armed <= 1'b0;
        end else if (unlock_set_in) begin
            unlock <= 1'b1;
            unlock_armed <= 1'b0;
        end else if (unlock && insn_done_in) begin
            if (unlock_armed || ctrl_wr_in) begin
                unlock <= 1'b0;
                unlock_armed <= 1'b0;
            end else begin
                unlock_armed <= 1'b1;
            end
        end
    end

    // R12 locked writes ignored
    assign wr_ok = ctrl_wr_in && unlock;

    ////////////////////////////////////////////////////////////////////////////////
    // R1 prescale field
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            prescale <= WDC_CTRL_RESET[WDC_PRE_MSB:WDC_PRE_LSB];
            irq_sel <= WDC_CTRL_RESET[WDC_IRQ_SEL_BIT];
        end else if (wr_ok) begin
            prescale <= ctrl_wdata_in[WDC_PRE_MSB:WDC_PRE_LSB];
            irq_sel <= ctrl_wdata_in[WDC_IRQ_SEL_BIT];
        end
    end

    // R10 enable clear events
    // R8 enable write
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || smi_sync) begin
            enable <= 1'b0;
        end else if (expire && (!irq_sel || immediate)) begin
            enable <= 1'b0;
        end else if (wr_ok) begin
            enable <= ctrl_wdata_in[WDC_ENABLE_BIT];
        end
    end

    // R6 status set on timeout
    // R7 survives watchdog reset
    // A timeout in the same cycle as a clearing write wins, so no event is lost.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in && !wdt_reset_seen_in) begin
            status_flag <= 1'b0;
        end else if (expire) begin
            status_flag <= 1'b1;
        end else if (wr_ok && !ctrl_wdata_in[WDC_STATUS_BIT]) begin
            status_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // R1 period in crystal ticks
    // R3 codes above 1000 reserved
    // Reserved codes are treated as the longest period; software must not use them.
    // The limit is the last count of a period, because a full code 7 period overflows the counter.
    always_comb begin
        if (prescale[3]) begin
            limit = WDC_COUNT_W'((WDC_BASE_TICKS << 7) - 1);
        end else begin
            limit = WDC_COUNT_W'((WDC_BASE_TICKS << prescale[2:0]) - 1);
        end
    end

    // R2 immediate reset code
    assign immediate = (prescale == WDC_PRE_IMMEDIATE);

    // R9 refresh or expire
    // R8 counter restart
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state <= WDC_IDLE;
            count <= '0;
            expire <= 1'b0;
        end else begin
            expire <= 1'b0;
            case (state)
                WDC_IDLE: begin
                    count <= '0;
                    if (enable) begin
                        state <= WDC_RUN;
                    end
                end
                WDC_RUN: begin
                    if (!enable) begin
                        state <= WDC_IDLE;
                    end else if (wr_ok && ctrl_wdata_in[WDC_ENABLE_BIT]) begin
                        count <= '0;
                    end else if (immediate) begin
                        state <= WDC_FIRE;
                        expire <= 1'b1;
                    end else if (xtal_tick) begin
                        if (count == limit) begin
                            count <= '0;
                            state <= WDC_FIRE;
                            expire <= 1'b1;
                        end else begin
                            count <= count + 1'b1;
                        end
                    end
                end
                WDC_FIRE: begin
                    count <= '0;
                    state <= WDC_RUN;
                end
                default: begin
                    state <= WDC_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // R4 reset or interrupt
    // R5 unmaskable high priority
    // The request is not gated by the global enable; it stays until any accepted control write.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wdt_reset_req_out <= 1'b0;
            wdt_irq_out <= 1'b0;
            wdt_irq_high_prio_out <= 1'b0;
        end else begin
            wdt_reset_req_out <= expire && (!irq_sel || immediate);
            wdt_irq_high_prio_out <= 1'b1;
            if (expire && irq_sel && !immediate) begin
                wdt_irq_out <= 1'b1;
            end else if (wr_ok) begin
                wdt_irq_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ctrl_rdata_out <= 8'h00;
        end else begin
            ctrl_rdata_out <= {prescale, irq_sel, status_flag, enable, unlock};
        end
    end
endmodule // wdc_top
